// ### arp_prio_regs.vh
// Register map, field layout and reset values of the ARP/RARP and priority classifier
// Function
// R01: IP multicast bit 14 set marks IP multicast frames cross-VLAN.
// R02: Unicast bit 13 set marks unicast cross-VLAN only on learning table hit.
// R03: Bit 12 set marks RARP frames cross-VLAN.
// R04: Action 00 gives empty portmap; 01 gives broadcast portmap.
// R05: Action 10: non-CPU ingress to CPU only; CPU ingress to broadcast minus CPU.
// R06: Action 11: non-CPU ingress to CPU only; CPU ingress to default ports minus CPU.
// R07: Priority enable bit 9 set puts ARP/RARP in queue from bits 8:7.
// R08: Bits 6:5 pick egress tagging: default, unmodified, tagged, untagged.
// R09: Bit 4 set marks ARP frames cross-VLAN.
// R10: Bit 3 set marks ARP and RARP frames as management.
// R11: Bit 2 set marks ARP and RARP frames as span.
// R12: Bit 1 set traps ARP frames.
// R13: Bit 0 set traps RARP frames.
// R14: Tagged user priority n picks queue from map bits 2n+1:2n.
// R15: Priority enable clear: ARP/RARP use ordinary queue classification.
// R16: Priority map applies only to tagged frames; untagged use other sources.
// R17: CPU port identified by three-bit CPU port number field.
`ifndef ARP_PRIO_REGS_VH
`define ARP_PRIO_REGS_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define OFS_ARP_CTRL     12'h000
`define OFS_PRIO_MAP     12'h004
`define OFS_CPU_PORT     12'h008

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define B_IPMC_XVLAN     14
`define B_UC_XVLAN       13
`define B_RARP_XVLAN     12
`define B_ACT_HI         11
`define B_ACT_LO         10
`define B_PRIO_EN        9
`define B_QSEL_HI        8
`define B_QSEL_LO        7
`define B_TAG_HI         6
`define B_TAG_LO         5
`define B_ARP_XVLAN      4
`define B_MGMT           3
`define B_SPAN           2
`define B_ARP_TRAP       1
`define B_RARP_TRAP      0
`define CTRL_WMASK       16'h7fff
`define CPU_PORT_HI      15
`define CPU_PORT_LO      13

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_ARP_CTRL     16'h0000
`define RST_PRIO_MAP     16'h0000
`define RST_CPU_PORT     3'h0

`endif

// ### arp_rarp_vlan_priority_classifier.v
// ARP/RARP forwarding and VLAN user priority queue classifier with APB registers
//
// Chosen here: the APB slave port and the register addresses.
`include "arp_prio_regs.vh"
`default_nettype none

module arp_rarp_vlan_priority_classifier #(
   parameter NPORTS = 6
) (
   // Clock and reset
   input  wire              mclk,
   input  wire              reset,
   // APB slave
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [11:0]       paddr,
   input  wire [31:0]       pwdata,
   output reg  [31:0]       prdata,
   output reg               pready,
   output reg               pslverr,
   // Received frame descriptor
   input  wire              frameValid,
   input  wire              isArp,
   input  wire              isRarp,
   input  wire              isIpMulticast,
   input  wire              isUnicast,
   input  wire              learnHit,
   input  wire              isTagged,
   input  wire [2:0]        userPriority,
   input  wire [2:0]        ingressPort,
   input  wire [NPORTS-1:0] broadcastPortmap,
   input  wire [NPORTS-1:0] defaultPortmap,
   input  wire [1:0]        ordinaryQueue,
   // Classification result
   output reg               resultValid,
   output reg               arpRarpHit,
   output reg  [NPORTS-1:0] portmap,
   output reg               portmapOverride,
   output reg  [1:0]        queue,
   output reg  [1:0]        egressTagMode,
   output reg               crossVlan,
   output reg               management,
   output reg               span,
   output reg               trap
);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // Control word; bit 15 stays zero
   reg [15:0] arp_rarp_handling_control;
   // Two-bit queue field per user priority
   reg [15:0] tag_priority_queue_map;
   // Which physical port the CPU sits on
   reg [2:0]  cpu_port_number;

   // Two-bit queue field of the map for a given user priority
   function [1:0] mapQueue;
      input [15:0] map;
      input [2:0]  prio;
      begin
         mapQueue = map[{prio, 1'b0} +: 2];
      end
   endfunction

   // ----------------------------------------
   // APB slave, zero wait states
   // ----------------------------------------
   // Setup phase of a transfer; the access phase follows it
   wire        setup   = psel & ~penable;
   // Address decode against the three word addresses
   wire        hitCtrl = (paddr == `OFS_ARP_CTRL);
   wire        hitMap  = (paddr == `OFS_PRIO_MAP);
   wire        hitCpu  = (paddr == `OFS_CPU_PORT);
   wire        mapped  = hitCtrl | hitMap | hitCpu;
   // Completing edge of a transfer
   wire        access  = psel & penable & pready;
   reg  [31:0] next_prdata;

   // Read mux; unmapped reads and all writes return zero
   always @* begin
      next_prdata = 32'h0000_0000;
      if (~pwrite & hitCtrl)
         next_prdata = {16'h0000, arp_rarp_handling_control};
      if (~pwrite & hitMap)
         next_prdata = {16'h0000, tag_priority_queue_map};
      if (~pwrite & hitCpu)
         next_prdata = {16'h0000, cpu_port_number, 13'h0000};
   end

   // Ready raised in the setup cycle so each access phase lasts one cycle
   always @(posedge mclk or posedge reset) begin
      if (reset)
         pready <= 1'b0;
      else
         pready <= setup;
   end

   // Error answered with the ready pulse for any unmapped address
   always @(posedge mclk or posedge reset) begin
      if (reset)
         pslverr <= 1'b0;
      else
         pslverr <= setup & ~mapped;
   end

   // Read data captured at setup so it stands beside ready
   always @(posedge mclk or posedge reset) begin
      if (reset)
         prdata <= 32'h0000_0000;
      else if (setup)
         prdata <= next_prdata;
   end

   // Writes land only at the completing edge; bit 15 of control is reserved
   always @(posedge mclk or posedge reset) begin
      if (reset)
         arp_rarp_handling_control <= `RST_ARP_CTRL;
      else if (access & pwrite & hitCtrl)
         arp_rarp_handling_control <= pwdata[15:0] & `CTRL_WMASK;
   end

   // Priority map takes the whole low half word
   always @(posedge mclk or posedge reset) begin
      if (reset)
         tag_priority_queue_map <= `RST_PRIO_MAP;
      else if (access & pwrite & hitMap)
         tag_priority_queue_map <= pwdata[15:0];
   end

   // CPU port number sits in the top three bits of the half word
   always @(posedge mclk or posedge reset) begin
      if (reset)
         cpu_port_number <= `RST_CPU_PORT;
      else if (access & pwrite & hitCpu)
         cpu_port_number <= pwdata[`CPU_PORT_HI:`CPU_PORT_LO]; // R17
   end

   // ----------------------------------------
   // Classification, one cycle latency
   // ----------------------------------------

   // ----------------------------------------
   // Control field views
   // ----------------------------------------
   // Named views keep the decode below readable
   wire [15:0]       c                            = arp_rarp_handling_control;
   wire              ip_multicast_cross_vlan      = c[`B_IPMC_XVLAN];          // R01
   wire              unicast_cross_vlan           = c[`B_UC_XVLAN];            // R02
   wire              rarp_cross_vlan              = c[`B_RARP_XVLAN];          // R03
   wire [1:0]        arp_rarp_portmap_action      = c[`B_ACT_HI:`B_ACT_LO];    // R04
   wire              arp_rarp_priority_enable     = c[`B_PRIO_EN];             // R07
   wire [1:0]        arp_rarp_queue_select        = c[`B_QSEL_HI:`B_QSEL_LO];  // R07
   wire [1:0]        arp_rarp_egress_tag_handling = c[`B_TAG_HI:`B_TAG_LO];    // R08
   wire              arp_cross_vlan               = c[`B_ARP_XVLAN];           // R09
   wire              arp_rarp_as_management       = c[`B_MGMT];                // R10
   wire              arp_rarp_as_span             = c[`B_SPAN];                // R11
   wire              arp_trap_enable              = c[`B_ARP_TRAP];            // R12
   wire              rarp_trap_enable             = c[`B_RARP_TRAP];           // R13

   // ----------------------------------------
   // Per-priority queue fields of the map
   // ----------------------------------------
   // One view per user priority; fields sit two bits apart
   wire [1:0]        user_prio0_queue = mapQueue(tag_priority_queue_map, 3'h0);
   wire [1:0]        user_prio1_queue = mapQueue(tag_priority_queue_map, 3'h1);
   wire [1:0]        user_prio2_queue = mapQueue(tag_priority_queue_map, 3'h2);
   wire [1:0]        user_prio3_queue = mapQueue(tag_priority_queue_map, 3'h3);
   wire [1:0]        user_prio4_queue = mapQueue(tag_priority_queue_map, 3'h4);
   wire [1:0]        user_prio5_queue = mapQueue(tag_priority_queue_map, 3'h5);
   wire [1:0]        user_prio6_queue = mapQueue(tag_priority_queue_map, 3'h6);
   wire [1:0]        user_prio7_queue = mapQueue(tag_priority_queue_map, 3'h7);

   // ----------------------------------------
   // Frame decode
   // ----------------------------------------
   // Either protocol takes the same portmap, queue and tag path
   wire              arpAny  = isArp | isRarp;
   // A CPU port number of six or more matches no physical port
   wire              fromCpu = (ingressPort == cpu_port_number);               // R17
   wire [NPORTS-1:0] cpuMask = {{(NPORTS-1){1'b0}}, 1'b1} << cpu_port_number;  // R17

   // Portmap for one action code; CPU port dropped on CPU ingress for codes 10 and 11
   function [NPORTS-1:0] pickPortmap;
      input [1:0]        code;
      input              cpuIn;
      input [NPORTS-1:0] bcast;
      input [NPORTS-1:0] dflt;
      input [NPORTS-1:0] cpuBit;
      begin
         case (code)
            2'b00: pickPortmap = {NPORTS{1'b0}};                      // R04
            2'b01: pickPortmap = bcast;                               // R04
            2'b10: pickPortmap = cpuIn ? (bcast & ~cpuBit) : cpuBit;  // R05
            2'b11: pickPortmap = cpuIn ? (dflt & ~cpuBit) : cpuBit;   // R06
            default: pickPortmap = {NPORTS{1'b0}};
         endcase
      end
   endfunction

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   reg  [NPORTS-1:0] next_portmap;
   reg  [1:0]        next_mapQueue;
   reg  [1:0]        next_queue;
   reg  [1:0]        next_egressTagMode;
   reg               next_crossVlan;
   reg               next_management;
   reg               next_span;
   reg               next_trap;

   // Only ARP/RARP frames get an action portmap; others see zero
   always @* begin
      if (arpAny)
         next_portmap = pickPortmap(arp_rarp_portmap_action, fromCpu, broadcastPortmap,
                                    defaultPortmap, cpuMask);          // R04 R05 R06
      else
         next_portmap = {NPORTS{1'b0}};
   end

   // Tag priority lookup; a case keeps the mux flat
   always @* begin
      case (userPriority)
         3'h0: next_mapQueue = user_prio0_queue;                      // R14
         3'h1: next_mapQueue = user_prio1_queue;                      // R14
         3'h2: next_mapQueue = user_prio2_queue;                      // R14
         3'h3: next_mapQueue = user_prio3_queue;                      // R14
         3'h4: next_mapQueue = user_prio4_queue;                      // R14
         3'h5: next_mapQueue = user_prio5_queue;                      // R14
         3'h6: next_mapQueue = user_prio6_queue;                      // R14
         3'h7: next_mapQueue = user_prio7_queue;                      // R14
         default: next_mapQueue = user_prio0_queue;
      endcase
   end

   // Queue: ARP override first, then tag priority, else ordinary source
   always @* begin
      if (arpAny & arp_rarp_priority_enable)
         next_queue = arp_rarp_queue_select;                          // R07
      else if (isTagged)
         next_queue = next_mapQueue;                                  // R14 R15
      else
         next_queue = ordinaryQueue;                                  // R16
   end

   // Tag handling only means something for ARP/RARP frames
   always @* begin
      if (arpAny)
         next_egressTagMode = arp_rarp_egress_tag_handling;           // R08
      else
         next_egressTagMode = 2'b00;
   end

   // Cross-VLAN marking from any of the four sources
   always @* begin
      next_crossVlan = 1'b0;
      if (ip_multicast_cross_vlan & isIpMulticast)
         next_crossVlan = 1'b1;                                       // R01
      if (unicast_cross_vlan & isUnicast & learnHit)
         next_crossVlan = 1'b1;                                       // R02
      if (rarp_cross_vlan & isRarp)
         next_crossVlan = 1'b1;                                       // R03
      if (arp_cross_vlan & isArp)
         next_crossVlan = 1'b1;                                       // R09
   end

   // Management, span and trap flags; trap is per protocol
   always @* begin
      next_management = arp_rarp_as_management & arpAny;             // R10
      next_span       = arp_rarp_as_span & arpAny;                    // R11
      next_trap       = (arp_trap_enable & isArp) |                   // R12
                        (rarp_trap_enable & isRarp);                  // R13
   end

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   // Result pulse, one cycle behind the descriptor strobe
   always @(posedge mclk or posedge reset) begin
      if (reset)
         resultValid <= 1'b0;
      else
         resultValid <= frameValid;
   end

   // Hit and override flags, qualified by the descriptor strobe
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         arpRarpHit      <= 1'b0;
         portmapOverride <= 1'b0;
      end else begin
         arpRarpHit      <= frameValid & arpAny;
         portmapOverride <= frameValid & arpAny;
      end
   end

   // Portmap follows its inputs each cycle; read it with resultValid
   always @(posedge mclk or posedge reset) begin
      if (reset)
         portmap <= {NPORTS{1'b0}};
      else
         portmap <= next_portmap;
   end

   // Queue left unqualified to save a gate level on the path
   always @(posedge mclk or posedge reset) begin
      if (reset)
         queue <= 2'b00;
      else
         queue <= next_queue;
   end

   // Tag mode, zero for every frame that is not ARP/RARP
   always @(posedge mclk or posedge reset) begin
      if (reset)
         egressTagMode <= 2'b00;
      else
         egressTagMode <= next_egressTagMode;
   end

   // Cross-VLAN flag, gated so an idle cycle never flags
   always @(posedge mclk or posedge reset) begin
      if (reset)
         crossVlan <= 1'b0;
      else
         crossVlan <= frameValid & next_crossVlan;
   end

   // Remaining flags, gated the same way
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         management <= 1'b0;
         span       <= 1'b0;
         trap       <= 1'b0;
      end else begin
         management <= frameValid & next_management;
         span       <= frameValid & next_span;
         trap       <= frameValid & next_trap;
      end
   end

endmodule // arp_rarp_vlan_priority_classifier

`default_nettype wire

// ### arp_rarp_chk.sv
// Port-level assertions for the ARP/RARP and priority classifier
`default_nettype none
module arp_rarp_chk #(parameter NPORTS = 6) (
   // Clock, reset and bus
   input wire logic              mclk,
   input wire logic              reset,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic [31:0]       prdata,
   // Descriptor and result
   input wire logic              frameValid,
   input wire logic              isArp,
   input wire logic              isRarp,
   input wire logic              isTagged,
   input wire logic [1:0]        ordinaryQueue,
   input wire logic              resultValid,
   input wire logic              arpRarpHit,
   input wire logic              portmapOverride,
   input wire logic [NPORTS-1:0] portmap,
   input wire logic [1:0]        egressTagMode,
   input wire logic [1:0]        queue,
   input wire logic              trap
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   bus_answer_a: assert property (psel && !penable |=> pready) else $error("no answer");
   bus_pulse_a: assert property (pready |=> !pready) else $error("answer too long");
   bus_error_a: assert property (pslverr |-> pready && prdata == 0) else $error("bad error");
   result_delay_a: assert property (frameValid |=> resultValid) else $error("late result");
   result_only_a: assert property (!frameValid |=> !resultValid) else $error("stray result");
   hit_flag_a: assert property (frameValid |=> arpRarpHit == $past(isArp || isRarp))
      else $error("wrong hit flag");
   other_clean_a: assert property (frameValid && !isArp && !isRarp |=>
      portmap == 0 && egressTagMode == 0 && !trap) else $error("other frame touched");
   untag_queue_a: assert property (frameValid && !isArp && !isRarp && !isTagged
      |=> queue == $past(ordinaryQueue)) else $error("untagged queue wrong");
   override_flag_a: assert property (frameValid |=> portmapOverride == $past(isArp || isRarp))
      else $error("wrong override flag");
endmodule // arp_rarp_chk
bind arp_rarp_vlan_priority_classifier arp_rarp_chk #(.NPORTS(NPORTS)) chk_i (
   .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .prdata(prdata), .frameValid(frameValid), .isArp(isArp),
   .isRarp(isRarp), .isTagged(isTagged), .ordinaryQueue(ordinaryQueue),
   .resultValid(resultValid), .arpRarpHit(arpRarpHit), .portmapOverride(portmapOverride),
   .portmap(portmap), .egressTagMode(egressTagMode), .queue(queue), .trap(trap)
);
`default_nettype wire

// ### test_arp_rarp_vlan_priority_classifier.sv
// Self-checking bench for the ARP/RARP and priority classifier
`include "arp_prio_regs.vh"
`default_nettype none
module test_arp_rarp_vlan_priority_classifier;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Stimulus and checks
   // ----------------------------------------
   logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, frameValid = 0, err;
   logic isArp = 0, isRarp = 0, isIpMulticast = 0, isUnicast = 0, learnHit = 0, isTagged = 0;
   logic [2:0] userPriority = 0, ingressPort = 0;
   logic [1:0] ordinaryQueue = 0, queue, egressTagMode;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [5:0] portmap, broadcastPortmap = 6'h3f, defaultPortmap = 6'h15;
   logic pready, pslverr, resultValid, arpRarpHit, portmapOverride;
   logic crossVlan, management, span, trap;
   logic [5:0] pmOther [4] = '{6'h00, 6'h3f, 6'h04, 6'h04};
   logic [5:0] pmCpu [4] = '{6'h00, 6'h3f, 6'h3b, 6'h11};
   int badCount = 0, cmpCount = 0;
   arp_rarp_vlan_priority_classifier arp_rarp_vlan_priority_classifier_i (
      .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .frameValid(frameValid), .isArp(isArp), .isRarp(isRarp),
      .isIpMulticast(isIpMulticast), .isUnicast(isUnicast), .learnHit(learnHit),
      .isTagged(isTagged), .userPriority(userPriority), .ingressPort(ingressPort),
      .broadcastPortmap(broadcastPortmap), .defaultPortmap(defaultPortmap),
      .ordinaryQueue(ordinaryQueue), .resultValid(resultValid), .arpRarpHit(arpRarpHit),
      .portmap(portmap), .portmapOverride(portmapOverride), .queue(queue),
      .egressTagMode(egressTagMode), .crossVlan(crossVlan), .management(management),
      .span(span), .trap(trap)
   );
   initial forever #2 mclk = ~mclk;
   task check(input logic [31:0] seen, input logic [31:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         badCount++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Held until pready is seen high at an edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge mclk) penable <= 1;
      do @(posedge mclk); while (pready !== 1);
      {rd, err} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
      @(posedge mclk);
   endtask
   task frame(input logic [5:0] f, input logic [2:0] prio, port, input logic [14:0] exp);
      {isArp, isRarp, isIpMulticast, isUnicast, learnHit, isTagged} <= f;
      {frameValid, userPriority, ingressPort, ordinaryQueue} <= {1'b1, prio, port, 2'd1};
      @(posedge mclk) frameValid <= 0;
      #1 check({resultValid, portmap, queue, egressTagMode, crossVlan, management, span, trap}, exp);
      @(posedge mclk);
   endtask
   task finishTest;
      $display("Counts: %0d compares, %0d mismatches", cmpCount, badCount);
      if (badCount == 0 && cmpCount > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Watchdog far beyond the roughly 110 cycles of the run
   initial begin
      #20000 badCount++;
      finishTest();
   end
   initial begin
      repeat (10) @(posedge mclk);
      reset <= 0;
      @(posedge mclk);
      apb(1, `OFS_ARP_CTRL, 32'h0000_ffff);
      apb(0, `OFS_ARP_CTRL, 0);
      check(rd, 32'h0000_7fff);
      apb(0, 12'h00c, 0);
      check({err, rd[30:0]}, 32'h8000_0000);
      $display("Register test done");
      apb(1, `OFS_PRIO_MAP, 32'h0000_e4e4);
      for (int n = 0; n < 8; n++) frame(6'b000001, n[2:0], 0, {1'b1, 6'h00, n[1:0], 6'h00});
      frame(6'b000000, 7, 0, {1'b1, 6'h00, 2'd1, 6'h00});
      apb(1, `OFS_CPU_PORT, 32'h0000_4000);
      for (int c = 0; c < 4; c++) begin
         apb(1, `OFS_ARP_CTRL, c << 10);
         frame(6'b100000, 0, 0, {1'b1, pmOther[c], 2'd1, 6'h00});
         frame(6'b010000, 0, 2, {1'b1, pmCpu[c], 2'd1, 6'h00});
         apb(1, `OFS_ARP_CTRL, 32'h0000_039f | c << 5);
         frame(6'b100000, 0, 0, {1'b1, 6'h00, 2'd3, c[1:0], 4'hf});
      end
      $display("Portmap and queue test done");
      apb(1, `OFS_ARP_CTRL, 32'h0000_7001);
      frame(6'b010000, 0, 0, {1'b1, 6'h00, 2'd1, 6'h09});
      frame(6'b100000, 0, 0, {1'b1, 6'h00, 2'd1, 6'h00});
      frame(6'b001000, 0, 0, {1'b1, 6'h00, 2'd1, 6'h08});
      frame(6'b000110, 0, 0, {1'b1, 6'h00, 2'd1, 6'h08});
      frame(6'b000100, 0, 0, {1'b1, 6'h00, 2'd1, 6'h00});
      apb(1, `OFS_ARP_CTRL, 0);
      frame(6'b001000, 0, 0, {1'b1, 6'h00, 2'd1, 6'h00});
      $display("Flag test done");
      finishTest();
   end
endmodule // test_arp_rarp_vlan_priority_classifier
`default_nettype wire
